/* File: sarc_conv_ctrl.sv */
// sarc_conv_ctrl: sequencer, divider, accumulator and window compare of
// a 10-bit successive-approximation converter.
// assumes the analog macro presents its code on convData at the last
// converter clock of a conversion, and that software pulses are one cycle.
//
// Operation
// - writing start launches a conversion; start bit reads one while busy
// - single mode clears the start bit by hardware at completion
// - channel change during conversion applies only after it completes
// - result-ready flag is set when the triggered operation ends
// - interrupt requested only with flag, enable and global enable all set
// - flag sets on completion whether or not the interrupt is enabled
// - with event start enabled an incoming event while idle triggers a conversion; events while busy are dropped
// - event input is edge sensitive and sets the start bit
// - continuous mode restarts right after each completion, each sets flag
// - reference and channel apply only while enabled; power off otherwise
// - result is 10 bits (8 with resSel8), right justified
// - burst accumulation of up to 64 results into one result
// - window compare limits interrupts to below, above, inside or outside
// - configurable delay between burst samples with optional random variation
// - converter clock comes from a programmable divider of core clock
// - debugger halt stops the converter unless run-when-halted is set
// - channel field picks one of twelve pins, ground, reference or sensor
// - enabled touch controller takes control of starting conversions instead of software
// - after reset the reference selection is the internal reference
// - a normal conversion takes 13 converter clock cycles
// - flag clears on result read or on writing one to it
// - conversion begins on the next rising converter clock edge
// - divider counter held in reset while no conversion is ongoing
`timescale 1ns/1ps
module sarc_conv_ctrl (
   input wire logic core_clk,
   input wire logic rstn,
   input wire sarc_pkg::sarc_cfg_s cfg,
   input wire logic startWrite,
   input wire logic flagClearWrite,
   input wire logic resultRead,
   input wire logic globalIntEn,
   input wire logic eventIn,
   input wire logic debugHalted,
   input wire logic touchEnable,
   input wire logic touchStart,
   input wire logic [sarc_pkg::DATA_W-1:0] convData,
   output logic startBit,
   output logic resultReady,
   output logic intReq,
   output logic [sarc_pkg::ACC_W-1:0] result,
   output logic [4:0] appliedChan,
   output logic [2:0] appliedRef,
   output logic convPowerEn,
   output logic convClk,
   output logic sampleStart
);
   import sarc_pkg::*;

   sarc_state_e state_r, state_nxt;
   logic startBit_r, startBit_nxt;
   logic flag_r, flag_nxt;
   logic intReq_r, intReq_nxt;
   logic [ACC_W-1:0] result_r, result_nxt;
   logic [ACC_W-1:0] acc_r, acc_nxt;
   logic [4:0] chan_r, chan_nxt;
   logic [2:0] ref_r, ref_nxt;
   logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
   logic clk_r, clk_nxt;
   logic [3:0] cycCnt_r, cycCnt_nxt;
   logic [5:0] sampCnt_r, sampCnt_nxt;
   logic [4:0] gapCnt_r, gapCnt_nxt;
   logic [3:0] lfsr_r, lfsr_nxt;
   logic evPrev_r, evPrev_nxt;
   logic winHit_r, winHit_nxt;
   logic sampleStart_r, sampleStart_nxt;
   logic halted, trigger, adcRise, doneNow;
   logic [DIV_W-1:0] halfDiv;
   logic [5:0] lastSample;
   logic [ACC_W-1:0] sample, total;

   // shared decode of triggers, divider edge and burst arithmetic
   always_comb begin
      halted = debugHalted & ~cfg.runWhenHalted;
      // touch controller owns the start source while enabled
      trigger = touchEnable ? touchStart :
         (startWrite | (cfg.evStartEn & eventIn & ~evPrev_r));
      halfDiv = DIV_W'(1) << cfg.divSel;
      adcRise = (divCnt_r == halfDiv - DIV_W'(1)) & ~clk_r;
      lastSample = 6'((7'd1 << cfg.accumSel) - 7'd1);
      // reduced resolution drops the two low bits, still right justified
      sample = cfg.resSel8 ? ACC_W'(convData[DATA_W-1:2]) : ACC_W'(convData);
      total = acc_r + sample;
      doneNow = (state_r == SARC_CONV) & adcRise & (cycCnt_r == CONV_LAST) & ~halted
         & (sampCnt_r == lastSample) & cfg.enable;
   end

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      startBit_nxt = startBit_r;
      acc_nxt = acc_r;
      result_nxt = result_r;
      chan_nxt = chan_r;
      ref_nxt = ref_r;
      divCnt_nxt = divCnt_r;
      clk_nxt = clk_r;
      cycCnt_nxt = cycCnt_r;
      sampCnt_nxt = sampCnt_r;
      gapCnt_nxt = gapCnt_r;
      lfsr_nxt = {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
      evPrev_nxt = eventIn;
      winHit_nxt = winHit_r;
      sampleStart_nxt = 1'b0;
      flag_nxt = flag_r & ~(flagClearWrite | resultRead);
      // selections track software only when enabled and not converting
      if (cfg.enable && state_r == SARC_IDLE) begin
         chan_nxt = cfg.chanSel;
         ref_nxt = cfg.reference_select;
      end
      // divider runs only during a conversion and not halted; held at zero while idle, frozen while halted
      if (state_r == SARC_IDLE) begin
         divCnt_nxt = '0;
         clk_nxt = 1'b0;
      end else if (!halted) begin
         if (divCnt_r == halfDiv - DIV_W'(1)) begin
            divCnt_nxt = '0;
            clk_nxt = ~clk_r;
         end else begin
            divCnt_nxt = divCnt_r + DIV_W'(1);
         end
      end
      if (!cfg.enable) begin
         state_nxt = SARC_IDLE;
         startBit_nxt = 1'b0;
      end else if (!halted) begin
         unique case (state_r)
            SARC_IDLE: begin
               // busy states never look at trigger, so no restart
               if (trigger) begin
                  startBit_nxt = 1'b1;
                  state_nxt = SARC_WAIT;
                  acc_nxt = '0;
                  sampCnt_nxt = '0;
               end
            end
            SARC_WAIT: begin
               if (adcRise) begin
                  state_nxt = SARC_CONV;
                  cycCnt_nxt = '0;
                  sampleStart_nxt = 1'b1;
               end
            end
            SARC_CONV: begin
               if (adcRise) begin
                  cycCnt_nxt = cycCnt_r + 4'd1;
                  if (cycCnt_r == CONV_LAST) begin
                     acc_nxt = total;
                     if (sampCnt_r != lastSample) begin
                        // jitter of one converter clock breaks up aliasing
                        gapCnt_nxt = {1'b0, cfg.sampDelay} +
                           5'(cfg.delayVarEn & lfsr_r[0]);
                        sampCnt_nxt = sampCnt_r + 6'd1;
                        state_nxt = SARC_GAP;
                     end else begin
                        result_nxt = total;
                        chan_nxt = cfg.chanSel;
                        ref_nxt = cfg.reference_select;
                        winHit_nxt = (cfg.winMode == WIN_OFF) ||
                           (cfg.winMode == WIN_BELOW && total < cfg.winLow) ||
                           (cfg.winMode == WIN_ABOVE && total > cfg.winHigh) ||
                           (cfg.winMode == WIN_INSIDE && total >= cfg.winLow &&
                              total <= cfg.winHigh) ||
                           (cfg.winMode == WIN_OUTSIDE && (total < cfg.winLow ||
                              total > cfg.winHigh));
                        acc_nxt = '0;
                        sampCnt_nxt = '0;
                        if (cfg.contMode) begin
                           state_nxt = SARC_WAIT;
                        end else begin
                           state_nxt = SARC_IDLE;
                           startBit_nxt = 1'b0;
                        end
                     end
                  end
               end
            end
            SARC_GAP: begin
               if (adcRise) begin
                  if (gapCnt_r == 5'd0) begin
                     state_nxt = SARC_CONV;
                     cycCnt_nxt = '0;
                     sampleStart_nxt = 1'b1;
                  end else begin
                     gapCnt_nxt = gapCnt_r - 5'd1;
                  end
               end
            end
            default: state_nxt = SARC_IDLE;
         endcase
      end
      // set wins over a clear in the same cycle
      if (doneNow) begin
         flag_nxt = 1'b1;
      end
      intReq_nxt = flag_nxt & cfg.resIntEn & globalIntEn & winHit_nxt;
   end

   // sequencer registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= SARC_IDLE;
         startBit_r <= 1'b0;
         flag_r <= 1'b0;
         intReq_r <= 1'b0;
         result_r <= '0;
         acc_r <= '0;
         chan_r <= CHAN_RESET;
         ref_r <= REF_INTERNAL;
         divCnt_r <= '0;
         clk_r <= 1'b0;
         cycCnt_r <= '0;
         sampCnt_r <= '0;
         gapCnt_r <= '0;
         lfsr_r <= LFSR_SEED;
         evPrev_r <= 1'b0;
         winHit_r <= 1'b1;
         sampleStart_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         startBit_r <= startBit_nxt;
         flag_r <= flag_nxt;
         intReq_r <= intReq_nxt;
         result_r <= result_nxt;
         acc_r <= acc_nxt;
         chan_r <= chan_nxt;
         ref_r <= ref_nxt;
         divCnt_r <= divCnt_nxt;
         clk_r <= clk_nxt;
         cycCnt_r <= cycCnt_nxt;
         sampCnt_r <= sampCnt_nxt;
         gapCnt_r <= gapCnt_nxt;
         lfsr_r <= lfsr_nxt;
         evPrev_r <= evPrev_nxt;
         winHit_r <= winHit_nxt;
         sampleStart_r <= sampleStart_nxt;
      end
   end

   // power gate follows enable one cycle late; outputs are flops
   logic power_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         power_r <= 1'b0;
      end else begin
         power_r <= cfg.enable;
      end
   end

   assign startBit = startBit_r;
   assign resultReady = flag_r;
   assign intReq = intReq_r;
   assign result = result_r;
   assign appliedChan = chan_r;
   assign appliedRef = ref_r;
   assign convPowerEn = power_r;
   assign convClk = clk_r;
   assign sampleStart = sampleStart_r;

   // checks on the sequencer
   property p_busyShowsStart;
      @(posedge core_clk) disable iff (!rstn)
      (state_r != SARC_IDLE) |-> startBit_r;
   endproperty
   a_busyShowsStart: assert property (p_busyShowsStart) else $error("busy without start");

   property p_singleClears;
      @(posedge core_clk) disable iff (!rstn)
      (doneNow && !cfg.contMode) |=> (!startBit_r && state_r == SARC_IDLE);
   endproperty
   a_singleClears: assert property (p_singleClears) else $error("start not cleared");

   property p_chanLocked;
      @(posedge core_clk) disable iff (!rstn)
      (state_r == SARC_CONV && $past(state_r) == SARC_CONV) |-> $stable(chan_r);
   endproperty
   a_chanLocked: assert property (p_chanLocked) else $error("channel moved mid conversion");

   property p_doneFlag;
      @(posedge core_clk) disable iff (!rstn)
      doneNow |=> flag_r && result_r == $past(total);
   endproperty
   a_doneFlag: assert property (p_doneFlag) else $error("flag or result missing");

   property p_intGate;
      @(posedge core_clk) disable iff (!rstn)
      intReq_r == (flag_r && winHit_r && $past(cfg.resIntEn) && $past(globalIntEn));
   endproperty
   a_intGate: assert property (p_intGate) else $error("interrupt without flag");

   property p_eventTrig;
      @(posedge core_clk) disable iff (!rstn)
      (state_r == SARC_IDLE && cfg.enable && !halted && !touchEnable && cfg.evStartEn
         && eventIn && !evPrev_r) |=> (startBit_r && state_r == SARC_WAIT);
   endproperty
   a_eventTrig: assert property (p_eventTrig) else $error("event edge ignored");

   property p_contRestart;
      @(posedge core_clk) disable iff (!rstn)
      (doneNow && cfg.contMode) |=> (state_r == SARC_WAIT && startBit_r);
   endproperty
   a_contRestart: assert property (p_contRestart) else $error("no restart");

   property p_abort;
      @(posedge core_clk) disable iff (!rstn)
      (!cfg.enable && !flag_r) |=> (state_r == SARC_IDLE && !startBit_r && !flag_r);
   endproperty
   a_abort: assert property (p_abort) else $error("disable did not abort");

   property p_divHeld;
      @(posedge core_clk) disable iff (!rstn)
      (state_r == SARC_IDLE) |=> ($past(state_r) != SARC_IDLE || divCnt_r == '0);
   endproperty
   a_divHeld: assert property (p_divHeld) else $error("divider ran while idle");

   property p_haltFreeze;
      @(posedge core_clk) disable iff (!rstn)
      (halted && cfg.enable) |=> ($stable(cycCnt_r) && $stable(state_r));
   endproperty
   a_haltFreeze: assert property (p_haltFreeze) else $error("ran while halted");

   c_single: cover property (@(posedge core_clk) disable iff (!rstn)
      doneNow && !cfg.contMode);
   c_cont: cover property (@(posedge core_clk) disable iff (!rstn)
      doneNow && cfg.contMode);
   c_burst: cover property (@(posedge core_clk) disable iff (!rstn)
      doneNow && sampCnt_r != 6'd0);
endmodule

/* File: sarc_pkg.sv */
// sarc_pkg: constants and carrier types for the converter sequencer.
// assumes one peripheral clock domain; all users import sarc_pkg::*.
package sarc_pkg;
   localparam int DATA_W = 10;
   localparam int ACC_W = 16;
   localparam int CONV_CYCLES = 13;
   localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
   localparam int DIV_W = 8;
   localparam logic [2:0] REF_INTERNAL = 3'h0;
   localparam logic [4:0] CHAN_RESET = 5'h00;
   localparam logic [3:0] LFSR_SEED = 4'h9;
   // window compare modes
   localparam logic [2:0] WIN_OFF = 3'h0;
   localparam logic [2:0] WIN_BELOW = 3'h1;
   localparam logic [2:0] WIN_ABOVE = 3'h2;
   localparam logic [2:0] WIN_INSIDE = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE = 3'h4;

   typedef enum logic [3:0] {
      SARC_IDLE = 4'b0001,
      SARC_WAIT = 4'b0010,
      SARC_CONV = 4'b0100,
      SARC_GAP = 4'b1000
   } sarc_state_e;

   // software-held configuration bits
   typedef struct packed {
      logic enable;
      logic contMode;
      logic evStartEn;
      logic resIntEn;
      logic runWhenHalted;
      logic resSel8;
      logic delayVarEn;
      logic [4:0] chanSel;
      logic [2:0] reference_select;
      logic [2:0] divSel;
      logic [2:0] accumSel;
      logic [3:0] sampDelay;
      logic [2:0] winMode;
      logic [ACC_W-1:0] winLow;
      logic [ACC_W-1:0] winHigh;
   } sarc_cfg_s;
endpackage

/* File: sarc_partner_model.sv */
// sarc_partner_model: analog input mux and event network around the sequencer.
// assumes the sequencer samples convData at the end of a conversion.
`timescale 1ns/1ps
module sarc_partner_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [4:0] appliedChan,
   input wire logic convPowerEn,
   input wire logic evReq,
   output logic [sarc_pkg::DATA_W-1:0] convData,
   output logic eventIn
);
   import sarc_pkg::*;
   logic [1:0] evCnt_r;
   logic [1:0] evCnt_nxt;
   logic tog_r;
   // code follows the channel; unpowered macro gives a toggling pattern
   always_comb begin
      if (convPowerEn) begin
         convData = 10'h100 + 10'(appliedChan);
      end else begin
         convData = {5{tog_r, ~tog_r}};
      end
   end
   // each event holds the line two cycles, so only its edge counts
   always_comb begin
      evCnt_nxt = evCnt_r;
      if (evReq) begin
         evCnt_nxt = 2'h2;
      end else if (evCnt_r != 2'h0) begin
         evCnt_nxt = evCnt_r - 2'h1;
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         evCnt_r <= 2'h0;
         tog_r <= 1'b0;
      end else begin
         evCnt_r <= evCnt_nxt;
         tog_r <= ~tog_r;
      end
   end
   assign eventIn = (evCnt_r != 2'h0);
endmodule

/* File: sarc_conv_ctrl_tb.sv */
// sarc_conv_ctrl_tb: scenario tasks for the converter sequencer.
// assumes divSel 0 (converter clock = core clock / 2) and no sample delay
// unless a scenario sets them and puts them back before it returns.
`timescale 1ns/1ps
module sarc_conv_ctrl_tb;
   import sarc_pkg::*;
   logic core_clk, rstn, startWrite, flagClearWrite, resultRead, globalIntEn;
   logic eventIn, debugHalted, touchEnable, touchStart, evReq;
   logic startBit, resultReady, intReq, convPowerEn, convClk, sampleStart;
   logic [DATA_W-1:0] convData;
   logic [ACC_W-1:0] result;
   logic [4:0] appliedChan;
   logic [2:0] appliedRef;
   sarc_cfg_s cfg;
   int mismatches, nChecks, n, p;
   sarc_conv_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .cfg(cfg),
      .startWrite(startWrite), .flagClearWrite(flagClearWrite), .resultRead(resultRead),
      .globalIntEn(globalIntEn), .eventIn(eventIn), .debugHalted(debugHalted),
      .touchEnable(touchEnable), .touchStart(touchStart), .convData(convData),
      .startBit(startBit), .resultReady(resultReady), .intReq(intReq), .result(result),
      .appliedChan(appliedChan), .appliedRef(appliedRef), .convPowerEn(convPowerEn),
      .convClk(convClk), .sampleStart(sampleStart));
   sarc_partner_model i_far (.core_clk(core_clk), .rstn(rstn), .appliedChan(appliedChan),
      .convPowerEn(convPowerEn), .evReq(evReq), .convData(convData), .eventIn(eventIn));
   // 125 MHz clock
   always #4 core_clk = ~core_clk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic check1(input logic seen, input logic exp);
      check({15'h0, seen}, {15'h0, exp});
   endtask
   function automatic logic [15:0] code_of(input logic [4:0] ch);
      return 16'h0100 + 16'(ch);
   endfunction
   // inputs change 1 ns after the rising edge
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic start_sw;
      startWrite = 1'b1;
      tick;
      startWrite = 1'b0;
   endtask
   task automatic clear_flag;
      resultRead = 1'b1;
      tick;
      resultRead = 1'b0;
      tick;
   endtask
   // bounded wait for the flag, counting cycles and sample pulses
   task automatic wait_flag;
      n = 0;
      p = 0;
      while (resultReady !== 1'b1 && n < 2000) begin
         if (sampleStart === 1'b1) p++;
         tick;
         n++;
      end
      if (n >= 2000) begin
         mismatches++;
         report_and_stop;
      end
   endtask
   task automatic t_single;
      start_sw;
      check1(startBit, 1'b1);
      check1(convClk, 1'b0);
      tick;
      check1(sampleStart, 1'b1);
      check1(convClk, 1'b1);
      repeat (7) tick;
      start_sw; // second trigger while busy must be dropped
      wait_flag;
      // one divider half period, then 13 converter clocks of two cycles
      check(16'(n + 9), 16'(1 + 2 * CONV_CYCLES));
      // the only sample pulse came before the wait, so a restart shows here
      check(16'(p), 16'h0000);
      check(result, code_of(5'h03));
      check1(intReq, 1'b0);
      tick;
      check1(startBit, 1'b0);
      clear_flag;
      check1(resultReady, 1'b0);
      repeat (4) tick;
      check1(startBit, 1'b0);
      check1(convClk, 1'b0);
   endtask
   task automatic t_irq;
      cfg.resIntEn = 1'b1;
      start_sw;
      wait_flag;
      tick;
      check1(intReq, 1'b0);
      globalIntEn = 1'b1;
      repeat (2) tick;
      check1(intReq, 1'b1);
      flagClearWrite = 1'b1;
      tick;
      flagClearWrite = 1'b0;
      repeat (2) tick;
      check1(resultReady, 1'b0);
      check1(intReq, 1'b0);
      cfg.resIntEn = 1'b0;
   endtask
   task automatic t_event;
      evReq = 1'b1;
      tick;
      evReq = 1'b0;
      repeat (4) tick;
      check1(startBit, 1'b0);
      cfg.evStartEn = 1'b1;
      evReq = 1'b1;
      tick;
      evReq = 1'b0;
      tick;
      check1(startBit, 1'b1);
      wait_flag;
      check(16'(p), 16'h0001);
      clear_flag;
      check1(startBit, 1'b0);
      cfg.evStartEn = 1'b0;
   endtask
   // four samples, one converter clock of delay, then with variation on
   task automatic t_accum;
      cfg.accumSel = 3'h2;
      cfg.sampDelay = 4'h1;
      for (int v = 0; v < 2; v++) begin
         cfg.delayVarEn = 1'(v);
         start_sw;
         wait_flag;
         check(16'(p), 16'h0004);
         check(result, 16'(4 * code_of(5'h03)));
         check1(n >= 1 + 8 * CONV_CYCLES + 12 && n <= 1 + 8 * CONV_CYCLES + 12 + 6 * v, 1'b1);
         clear_flag;
      end
      cfg.accumSel = 3'h0;
      cfg.sampDelay = 4'h0;
      cfg.delayVarEn = 1'b0;
   endtask
   // divide by four and 8-bit resolution
   task automatic t_div;
      cfg.divSel = 3'h1;
      cfg.resSel8 = 1'b1;
      start_sw;
      wait_flag;
      check(16'(n), 16'(2 + 4 * CONV_CYCLES));
      check(result, code_of(5'h03) >> 2);
      clear_flag;
      cfg.divSel = 3'h0;
      cfg.resSel8 = 1'b0;
   endtask
   task automatic win_case(input logic [2:0] mode, input logic [15:0] lo, input logic [15:0] hi,
      input logic expIrq);
      cfg.winMode = mode;
      cfg.winLow = lo;
      cfg.winHigh = hi;
      start_sw;
      wait_flag;
      check1(intReq, expIrq);
      check1(resultReady, 1'b1);
      clear_flag;
   endtask
   // result is 0x103 on channel 3; each mode once missed, once hit
   task automatic t_window;
      cfg.resIntEn = 1'b1;
      globalIntEn = 1'b1;
      win_case(WIN_BELOW, 16'h0100, 16'h0110, 1'b0);
      win_case(WIN_BELOW, 16'h0104, 16'h0110, 1'b1);
      win_case(WIN_ABOVE, 16'h0100, 16'h0103, 1'b0);
      win_case(WIN_ABOVE, 16'h0100, 16'h0102, 1'b1);
      win_case(WIN_INSIDE, 16'h0100, 16'h0110, 1'b1);
      win_case(WIN_INSIDE, 16'h0104, 16'h0110, 1'b0);
      win_case(WIN_OUTSIDE, 16'h0100, 16'h0110, 1'b0);
      win_case(WIN_OUTSIDE, 16'h0104, 16'h0110, 1'b1);
      cfg.winMode = WIN_OFF;
      cfg.resIntEn = 1'b0;
   endtask
   task automatic t_chan;
      cfg.chanSel = 5'h05;
      repeat (2) tick;
      start_sw;
      repeat (6) tick;
      cfg.chanSel = 5'h07;
      tick;
      check({11'h0, appliedChan}, 16'h0005);
      wait_flag;
      check(result, code_of(5'h05));
      clear_flag;
      check({11'h0, appliedChan}, 16'h0007);
   endtask
   task automatic t_cont;
      cfg.contMode = 1'b1;
      start_sw;
      wait_flag;
      clear_flag;
      check1(startBit, 1'b1);
      wait_flag;
      check1(resultReady, 1'b1);
      cfg.contMode = 1'b0;
      clear_flag;
      wait_flag;
      clear_flag;
      check1(startBit, 1'b0);
   endtask
   task automatic t_refuse;
      debugHalted = 1'b1;
      start_sw;
      repeat (3) tick;
      check1(startBit, 1'b0);
      debugHalted = 1'b0;
      touchEnable = 1'b1;
      start_sw;
      repeat (3) tick;
      check1(startBit, 1'b0);
      touchStart = 1'b1;
      tick;
      touchStart = 1'b0;
      tick;
      check1(startBit, 1'b1);
      wait_flag;
      clear_flag;
      touchEnable = 1'b0;
      // halt in mid conversion freezes it for exactly the halted cycles
      start_sw;
      repeat (4) tick;
      debugHalted = 1'b1;
      repeat (20) tick;
      check1(startBit, 1'b1);
      check1(resultReady, 1'b0);
      debugHalted = 1'b0;
      wait_flag;
      check(16'(n + 24), 16'(1 + 2 * CONV_CYCLES + 20));
      check(result, code_of(5'h03));
      clear_flag;
      // run-when-halted keeps the converter going at full speed
      cfg.runWhenHalted = 1'b1;
      debugHalted = 1'b1;
      start_sw;
      wait_flag;
      check(16'(n), 16'(1 + 2 * CONV_CYCLES));
      clear_flag;
      debugHalted = 1'b0;
      cfg.runWhenHalted = 1'b0;
   endtask
   task automatic t_abort;
      start_sw;
      repeat (8) tick;
      cfg.enable = 1'b0;
      cfg.chanSel = 5'h09;
      repeat (3) tick;
      check1(startBit, 1'b0);
      check1(convPowerEn, 1'b0);
      repeat (40) tick;
      check1(resultReady, 1'b0);
      check({11'h0, appliedChan}, 16'h0003);
   endtask
   // reset, configure with enable last, then the scenarios
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      cfg = '0;
      {startWrite, flagClearWrite, resultRead, globalIntEn, evReq} = 5'h00;
      {debugHalted, touchEnable, touchStart} = 3'h0;
      mismatches = 0;
      nChecks = 0;
      repeat (4) tick;
      rstn = 1'b1;
      check({13'h0, appliedRef}, {13'h0, REF_INTERNAL});
      cfg.chanSel = 5'h03;
      cfg.reference_select = 3'h2;
      tick;
      // selections wait for enable
      check({13'h0, appliedRef}, {13'h0, REF_INTERNAL});
      check({11'h0, appliedChan}, {11'h0, CHAN_RESET});
      cfg.enable = 1'b1;
      repeat (2) tick;
      check1(convPowerEn, 1'b1);
      check({13'h0, appliedRef}, 16'h0002);
      t_single;
      t_irq;
      t_event;
      t_accum;
      t_div;
      t_window;
      t_chan;
      cfg.chanSel = 5'h03;
      t_cont;
      t_refuse;
      t_abort;
      report_and_stop;
   end
endmodule
